// [hw/gpibc_top.sv]
// instrument bus controller: init, byte transfer, serial/parallel poll, service irq
// assumes APB master on pclk; bus pin inputs synchronous to pclk
`timescale 1ns/1ps
module gpibc_top #(
	parameter int IFC_CYCLES = gpibc_pkg::IFC_CYCLES,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic gpib_ifc_n,
	output logic gpib_ren_n,
	output logic gpib_atn_n,
	input wire logic gpib_srq_n,
	input wire logic gpib_eoi_n_i,
	output logic gpib_eoi_n_o,
	output logic gpib_eoi_n_oe,
	input wire logic gpib_dav_n_i,
	output logic gpib_dav_n_o,
	output logic gpib_dav_n_oe,
	input wire logic gpib_nrfd_n_i,
	output logic gpib_nrfd_n_o,
	output logic gpib_nrfd_n_oe,
	input wire logic gpib_ndac_n_i,
	output logic gpib_ndac_n_o,
	output logic gpib_ndac_n_oe,
	input wire logic [7:0] gpib_dio_n_i,
	output logic [7:0] gpib_dio_n_o,
	output logic gpib_dio_n_oe,
	output logic srq_irq
);
	initial begin
		if (IFC_CYCLES < 1 || FIFO_DEPTH < 2) begin
			$error("IFC_CYCLES must be positive and FIFO_DEPTH at least 2");
		end
	end

	// ----------------------------------------------------------------
	// sequencer table
	// ----------------------------------------------------------------
	function automatic logic [10:0] seq_item(input logic [3:0] op, input logic [3:0] step,
		input logic [4:0] a, input logic [7:0] b);
		logic [10:0] r;
		r = {gpibc_pkg::K_DONE, 8'h00};
		case (op)
			gpibc_pkg::OP_INIT: begin
				if (step == 4'h0) begin
					r = {gpibc_pkg::K_IFC, 8'h00};
				end else if (step == 4'h1) begin
					r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_DEV_CLEAR};
				end else if (step == 4'h2) begin
					r = {gpibc_pkg::K_SETTLE, 8'h00};
				end
			end
			gpibc_pkg::OP_RAWCMD: begin
				if (step == 4'h0) begin
					r = {gpibc_pkg::K_CMD, b};
				end
			end
			gpibc_pkg::OP_RAWRD: begin
				if (step == 4'h0) begin
					r = {gpibc_pkg::K_RX, 8'h00};
				end
			end
			gpibc_pkg::OP_SEND: begin
				if (step == 4'h0) begin
					r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_UNLISTEN};
				end else if (step == 4'h1) begin
					r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_LISTEN_BASE | {3'h0, a}};
				end else if (step == 4'h2) begin
					r = {gpibc_pkg::K_DATA, 8'h00};
				end
			end
			gpibc_pkg::OP_RECV: begin
				if (step == 4'h0) begin
					r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_UNLISTEN};
				end else if (step == 4'h1) begin
					r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_TALK_BASE | {3'h0, a}};
				end else if (step == 4'h2) begin
					r = {gpibc_pkg::K_RX, 8'h00};
				end else if (step == 4'h3) begin
					r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_UNTALK};
				end
			end
			gpibc_pkg::OP_POLL, gpibc_pkg::OP_SERVICE: begin
				case (step)
					4'h0: r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_SPOLL_ON};
					4'h1: r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_TALK_BASE | {3'h0, a}};
					4'h2: r = {gpibc_pkg::K_RX, 8'h00};
					4'h3: r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_SPOLL_OFF};
					4'h4: r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_UNTALK};
					4'h5: begin
						if (op == gpibc_pkg::OP_SERVICE) begin
							r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_TALK_BASE | {3'h0, a}};
						end
					end
					4'h6: r = {gpibc_pkg::K_RX, 8'h00};
					4'h7: r = {gpibc_pkg::K_CMD, gpibc_pkg::BC_UNTALK};
					default: r = {gpibc_pkg::K_DONE, 8'h00};
				endcase
			end
			gpibc_pkg::OP_PARALLEL_STATUS_QUERY: begin
				if (step == 4'h0) begin
					r = {gpibc_pkg::K_PARALLEL_STATUS_QUERY, 8'h00};
				end
			end
			default: r = {gpibc_pkg::K_DONE, 8'h00};
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	gpibc_pkg::gpibc_state_t state_q;
	gpibc_pkg::gpibc_irq_mode_t irq_mode_q;
	logic [3:0] op_q;
	logic [3:0] step_q;
	logic [4:0] addr_q;
	logic [7:0] cmd_byte_q;
	logic [2:0] kind_q;
	logic hs_q;
	logic atn_q;
	logic [7:0] dio_q;
	logic [31:0] timer_q;
	logic [7:0] rx_q;
	logic rx_valid_q;
	logic [7:0] spoll_q;
	logic found_q;
	logic [7:0] parallel_status_query_q;
	logic [31:0] settle_q;
	logic auto_q;
	logic ren_q;
	logic srq_prev_q;
	logic srq_seen_q;
	logic irq_pend_q;
	logic [31:0] prdata_q;
	logic [10:0] item;
	logic [2:0] item_kind;
	logic [7:0] item_byte;
	logic srq_fall;
	logic acc_phase;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic cmd_go;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic [31:0] rd_word;
	logic src_accepted;
	logic rx_take;
	logic rx_to_spoll;
	logic timer_end;

	assign item = seq_item(op_q, step_q, addr_q, cmd_byte_q);
	assign item_kind = item[10:8];
	assign item_byte = item[7:0];

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign acc_phase = psel && penable;
	assign mapped = (paddr == gpibc_pkg::REG_CMD) || (paddr == gpibc_pkg::REG_STATUS) ||
		(paddr == gpibc_pkg::REG_TXDATA) || (paddr == gpibc_pkg::REG_RXDATA) ||
		(paddr == gpibc_pkg::REG_SPOLL) || (paddr == gpibc_pkg::REG_PARALLEL_STATUS_QUERY) ||
		(paddr == gpibc_pkg::REG_IRQCTL) || (paddr == gpibc_pkg::REG_SETTLE) ||
		(paddr == gpibc_pkg::REG_CTRL);
	assign fifo_in_valid = acc_phase && pwrite && (paddr == gpibc_pkg::REG_TXDATA);
	// a tx write stalls the master while the fifo is full
	assign pready = fifo_in_valid ? fifo_in_ready : 1'b1;
	assign pslverr = acc_phase && !mapped;
	assign wr_en = acc_phase && pwrite && pready && mapped;
	assign rd_en = acc_phase && !pwrite && mapped;
	assign cmd_go = wr_en && (paddr == gpibc_pkg::REG_CMD) && (state_q == gpibc_pkg::ST_IDLE);
	assign prdata = prdata_q;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (paddr == gpibc_pkg::REG_STATUS) begin
			rd_word = {19'h0, addr_q, !fifo_in_ready, irq_mode_q, irq_pend_q, !gpib_srq_n,
				found_q, rx_valid_q, state_q != gpibc_pkg::ST_IDLE};
		end else if (paddr == gpibc_pkg::REG_RXDATA) begin
			rd_word = {24'h0, rx_q};
		end else if (paddr == gpibc_pkg::REG_SPOLL) begin
			rd_word = {24'h0, spoll_q};
		end else if (paddr == gpibc_pkg::REG_PARALLEL_STATUS_QUERY) begin
			rd_word = {24'h0, parallel_status_query_q};
		end else if (paddr == gpibc_pkg::REG_IRQCTL) begin
			rd_word = {29'h0, irq_pend_q, irq_mode_q};
		end else if (paddr == gpibc_pkg::REG_SETTLE) begin
			rd_word = settle_q;
		end else if (paddr == gpibc_pkg::REG_CTRL) begin
			rd_word = {30'h0, ren_q, auto_q};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_word;
		end
	end

	// ----------------------------------------------------------------
	// software settings
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q <= gpibc_pkg::SETTLE_RESET;
			auto_q <= 1'b0;
			ren_q <= 1'b0;
		end else begin
			if (wr_en && paddr == gpibc_pkg::REG_SETTLE) begin
				settle_q <= pwdata;
			end
			if (wr_en && paddr == gpibc_pkg::REG_CTRL) begin
				auto_q <= pwdata[gpibc_pkg::CTRL_AUTO_BIT];
				ren_q <= pwdata[gpibc_pkg::CTRL_REN_BIT];
			end else if (state_q == gpibc_pkg::ST_TIMED && kind_q == gpibc_pkg::K_IFC &&
				timer_end) begin
				ren_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// service request irq
	// ----------------------------------------------------------------
	assign srq_fall = srq_prev_q && !gpib_srq_n;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srq_prev_q <= 1'b1;
			irq_mode_q <= gpibc_pkg::IRQ_DISABLED;
			irq_pend_q <= 1'b0;
		end else begin
			srq_prev_q <= gpib_srq_n;
			if (wr_en && paddr == gpibc_pkg::REG_IRQCTL) begin
				if (pwdata[gpibc_pkg::IRQ_DISABLE_BIT]) begin
					irq_mode_q <= gpibc_pkg::IRQ_DISABLED;
				end else if (pwdata[gpibc_pkg::IRQ_HOLD_BIT]) begin
					irq_mode_q <= gpibc_pkg::IRQ_HELD;
				end else if (pwdata[gpibc_pkg::IRQ_ENABLE_BIT]) begin
					irq_mode_q <= gpibc_pkg::IRQ_ENABLED;
				end
			end
			if (wr_en && paddr == gpibc_pkg::REG_IRQCTL && pwdata[gpibc_pkg::IRQ_DISABLE_BIT]) begin
				irq_pend_q <= 1'b0;
			end else if (srq_fall && irq_mode_q != gpibc_pkg::IRQ_DISABLED) begin
				irq_pend_q <= 1'b1;
			end else if (wr_en && paddr == gpibc_pkg::REG_IRQCTL &&
				pwdata[gpibc_pkg::IRQ_CLEAR_BIT]) begin
				irq_pend_q <= 1'b0;
			end
		end
	end

	assign srq_irq = irq_pend_q && (irq_mode_q == gpibc_pkg::IRQ_ENABLED);

	// ----------------------------------------------------------------
	// bus sequencer
	// ----------------------------------------------------------------
	assign src_accepted = state_q == gpibc_pkg::ST_SRC && hs_q && gpib_ndac_n_i;
	assign fifo_out_ready = src_accepted && kind_q == gpibc_pkg::K_DATA;
	assign rx_take = state_q == gpibc_pkg::ST_ACC && !hs_q && !gpib_dav_n_i;
	assign rx_to_spoll = (op_q == gpibc_pkg::OP_POLL || op_q == gpibc_pkg::OP_SERVICE) &&
		step_q == gpibc_pkg::POLL_RX_STEP;
	assign timer_end = timer_q <= 32'h0000_0001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= gpibc_pkg::ST_IDLE;
			op_q <= 4'h0;
			step_q <= 4'h0;
			addr_q <= 5'h00;
			cmd_byte_q <= 8'h00;
			kind_q <= gpibc_pkg::K_DONE;
			hs_q <= 1'b0;
			atn_q <= 1'b0;
			dio_q <= 8'h00;
			timer_q <= 32'h0000_0000;
		end else begin
			case (state_q)
				gpibc_pkg::ST_IDLE: begin
					step_q <= 4'h0;
					if (cmd_go) begin
						op_q <= pwdata[gpibc_pkg::CMD_OP_LSB +: 4];
						addr_q <= pwdata[gpibc_pkg::CMD_ADDR_LSB +: 5];
						cmd_byte_q <= pwdata[gpibc_pkg::CMD_BYTE_LSB +: 8];
						state_q <= gpibc_pkg::ST_FETCH;
					end else if (auto_q && srq_seen_q) begin
						op_q <= gpibc_pkg::OP_SERVICE;
						addr_q <= 5'h00;
						state_q <= gpibc_pkg::ST_FETCH;
					end
				end
				gpibc_pkg::ST_FETCH: begin
					hs_q <= 1'b0;
					kind_q <= item_kind;
					if (op_q == gpibc_pkg::OP_SERVICE && step_q == gpibc_pkg::SVC_CHECK_STEP &&
						!spoll_q[gpibc_pkg::SRQ_BIT]) begin
						// not this one: poll the next address
						if (addr_q == gpibc_pkg::MAX_ADDR) begin
							state_q <= gpibc_pkg::ST_IDLE;
						end else begin
							addr_q <= addr_q + 5'h01;
							step_q <= 4'h0;
						end
					end else begin
						case (item_kind)
							gpibc_pkg::K_CMD: begin
								atn_q <= 1'b1;
								dio_q <= item_byte;
								state_q <= gpibc_pkg::ST_SRC;
							end
							gpibc_pkg::K_DATA: begin
								atn_q <= 1'b0;
								if (fifo_out_valid) begin
									dio_q <= fifo_out_data;
									state_q <= gpibc_pkg::ST_SRC;
								end else begin
									step_q <= step_q + 4'h1;
								end
							end
							gpibc_pkg::K_RX: begin
								atn_q <= 1'b0;
								state_q <= gpibc_pkg::ST_ACC;
							end
							gpibc_pkg::K_IFC: begin
								timer_q <= 32'(IFC_CYCLES);
								state_q <= gpibc_pkg::ST_TIMED;
							end
							gpibc_pkg::K_SETTLE: begin
								atn_q <= 1'b0;
								timer_q <= settle_q;
								state_q <= gpibc_pkg::ST_TIMED;
							end
							gpibc_pkg::K_PARALLEL_STATUS_QUERY: begin
								atn_q <= 1'b1;
								timer_q <= 32'(gpibc_pkg::PARALLEL_STATUS_QUERY_CYCLES);
								state_q <= gpibc_pkg::ST_TIMED;
							end
							default: begin
								atn_q <= 1'b0;
								state_q <= gpibc_pkg::ST_IDLE;
							end
						endcase
					end
				end
				gpibc_pkg::ST_SRC: begin
					if (!hs_q && gpib_nrfd_n_i) begin
						hs_q <= 1'b1;
					end else if (src_accepted) begin
						if (kind_q != gpibc_pkg::K_DATA) begin
							step_q <= step_q + 4'h1;
						end
						state_q <= gpibc_pkg::ST_FETCH;
					end
				end
				gpibc_pkg::ST_ACC: begin
					if (rx_take) begin
						hs_q <= 1'b1;
					end else if (hs_q && gpib_dav_n_i) begin
						step_q <= step_q + 4'h1;
						state_q <= gpibc_pkg::ST_FETCH;
					end
				end
				gpibc_pkg::ST_TIMED: begin
					timer_q <= timer_q - 32'h0000_0001;
					if (timer_end) begin
						if (kind_q == gpibc_pkg::K_PARALLEL_STATUS_QUERY) begin
							atn_q <= 1'b0;
						end
						step_q <= step_q + 4'h1;
						state_q <= gpibc_pkg::ST_FETCH;
					end
				end
				default: state_q <= gpibc_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// captured results
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= 8'h00;
			rx_valid_q <= 1'b0;
			spoll_q <= 8'h00;
			found_q <= 1'b0;
			parallel_status_query_q <= 8'h00;
			srq_seen_q <= 1'b0;
		end else begin
			if (rx_take && rx_to_spoll) begin
				spoll_q <= ~gpib_dio_n_i;
			end else if (rx_take) begin
				rx_q <= ~gpib_dio_n_i;
			end
			if (rx_take && !rx_to_spoll) begin
				rx_valid_q <= 1'b1;
			end else if (rd_en && paddr == gpibc_pkg::REG_RXDATA) begin
				rx_valid_q <= 1'b0;
			end
			if (rx_take && rx_to_spoll && !gpib_dio_n_i[gpibc_pkg::SRQ_BIT]) begin
				found_q <= 1'b1;
			end else if (cmd_go) begin
				found_q <= 1'b0;
			end
			if (state_q == gpibc_pkg::ST_TIMED && kind_q == gpibc_pkg::K_PARALLEL_STATUS_QUERY && timer_end) begin
				parallel_status_query_q <= ~gpib_dio_n_i;
			end
			if (srq_fall) begin
				srq_seen_q <= 1'b1;
			end else if (state_q == gpibc_pkg::ST_IDLE && !cmd_go) begin
				srq_seen_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// bus pins
	// ----------------------------------------------------------------
	assign gpib_ifc_n = !(state_q == gpibc_pkg::ST_TIMED && kind_q == gpibc_pkg::K_IFC);
	assign gpib_ren_n = !ren_q;
	assign gpib_atn_n = !atn_q;
	assign gpib_eoi_n_o = 1'b0;
	assign gpib_eoi_n_oe = state_q == gpibc_pkg::ST_TIMED && kind_q == gpibc_pkg::K_PARALLEL_STATUS_QUERY;
	assign gpib_dav_n_o = 1'b0;
	assign gpib_dav_n_oe = state_q == gpibc_pkg::ST_SRC && hs_q;
	assign gpib_nrfd_n_o = 1'b0;
	assign gpib_nrfd_n_oe = state_q == gpibc_pkg::ST_ACC && hs_q;
	assign gpib_ndac_n_o = 1'b0;
	assign gpib_ndac_n_oe = state_q == gpibc_pkg::ST_ACC && !hs_q;
	assign gpib_dio_n_o = ~dio_q;
	assign gpib_dio_n_oe = state_q == gpibc_pkg::ST_SRC;

	gpibc_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(pwdata[7:0]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);
endmodule

// [shared/gpibc_pkg.sv]
// constants for the instrument bus controller: register map, bus command bytes,
// sequencer kinds and timing; assumes a 125 MHz pclk
package gpibc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int IFC_TIME_NS = 100000;
	localparam int IFC_CYCLES = (IFC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PARALLEL_STATUS_QUERY_TIME_NS = 2000;
	localparam int PARALLEL_STATUS_QUERY_CYCLES = (PARALLEL_STATUS_QUERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_TIME_NS = 1000000;
	localparam logic [31:0] SETTLE_RESET = 32'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TXDATA = 8'h08;
	localparam logic [7:0] REG_RXDATA = 8'h0C;
	localparam logic [7:0] REG_SPOLL = 8'h10;
	localparam logic [7:0] REG_PARALLEL_STATUS_QUERY = 8'h14;
	localparam logic [7:0] REG_IRQCTL = 8'h18;
	localparam logic [7:0] REG_SETTLE = 8'h1C;
	localparam logic [7:0] REG_CTRL = 8'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_BYTE_LSB = 16;
	localparam int IRQ_ENABLE_BIT = 0;
	localparam int IRQ_DISABLE_BIT = 1;
	localparam int IRQ_HOLD_BIT = 2;
	localparam int IRQ_CLEAR_BIT = 3;
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_REN_BIT = 1;
	localparam int SRQ_BIT = 6;

	// ----------------------------------------------------------------
	// bus command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] BC_DEV_CLEAR = 8'h14;
	localparam logic [7:0] BC_SPOLL_ON = 8'h18;
	localparam logic [7:0] BC_SPOLL_OFF = 8'h19;
	localparam logic [7:0] BC_UNLISTEN = 8'h3F;
	localparam logic [7:0] BC_UNTALK = 8'h5F;
	localparam logic [7:0] BC_LISTEN_BASE = 8'h20;
	localparam logic [7:0] BC_TALK_BASE = 8'h40;
	localparam logic [4:0] MAX_ADDR = 5'h1E;

	// ----------------------------------------------------------------
	// operations, sequencer kinds, states
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_INIT = 4'h1;
	localparam logic [3:0] OP_RAWCMD = 4'h2;
	localparam logic [3:0] OP_RAWRD = 4'h3;
	localparam logic [3:0] OP_SEND = 4'h4;
	localparam logic [3:0] OP_RECV = 4'h5;
	localparam logic [3:0] OP_POLL = 4'h6;
	localparam logic [3:0] OP_SERVICE = 4'h7;
	localparam logic [3:0] OP_PARALLEL_STATUS_QUERY = 4'h8;
	localparam logic [3:0] SVC_CHECK_STEP = 4'h5;
	localparam logic [3:0] POLL_RX_STEP = 4'h2;

	localparam logic [2:0] K_DONE = 3'h0;
	localparam logic [2:0] K_CMD = 3'h1;
	localparam logic [2:0] K_RX = 3'h2;
	localparam logic [2:0] K_IFC = 3'h3;
	localparam logic [2:0] K_SETTLE = 3'h4;
	localparam logic [2:0] K_DATA = 3'h5;
	localparam logic [2:0] K_PARALLEL_STATUS_QUERY = 3'h6;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_SRC = 3'b011,
		ST_ACC = 3'b010,
		ST_TIMED = 3'b110
	} gpibc_state_t;

	typedef enum logic [1:0] {
		IRQ_DISABLED = 2'h0,
		IRQ_ENABLED = 2'h1,
		IRQ_HELD = 2'h2
	} gpibc_irq_mode_t;

endpackage

// [hw/gpibc_fifo.sv]
// synchronous fifo held in flip-flops, valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module gpibc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
			$error("fifo depth must be a power of two of at least 2");
		end
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem_q[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge pclk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// [verif/gpibc_properties.sv]
// assertion checker bound onto the controller top
// assumes gpibc_top ports, one clock, async active-low reset
`timescale 1ns/1ps
module gpibc_props #(
	parameter int IFC_CYCLES = 20
) (
	input wire logic pclk, presetn, psel, penable, pwrite, pready,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic gpib_ifc_n, gpib_ren_n, gpib_atn_n, gpib_dav_n_oe,
	input wire logic gpib_eoi_n_oe, gpib_dio_n_oe, srq_irq,
	input wire logic [7:0] gpib_dio_n_o
);
	int ifc_q;
	logic [1:0] nb_q;
	logic irq_wr;
	assign irq_wr = psel && penable && pready && pwrite && paddr == gpibc_pkg::REG_IRQCTL;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// clear low-time, bytes sourced since clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ifc_q <= 0;
			nb_q <= 2'h2;
		end else begin
			ifc_q <= gpib_ifc_n ? 0 : ifc_q + 1;
			if (!gpib_ifc_n)
				nb_q <= 2'h0;
			else if ($rose(gpib_dav_n_oe) && nb_q != 2'h2)
				nb_q <= nb_q + 2'h1;
		end
	end
	a_ifc_width: assert property ($rose(gpib_ifc_n) |-> ifc_q == IFC_CYCLES)
		else $error("interface clear width wrong");
	a_ifc_quiet: assert property (!gpib_ifc_n |-> gpib_atn_n && !gpib_dav_n_oe)
		else $error("bus traffic during interface clear");
	a_ren_follows: assert property ($rose(gpib_ifc_n) |-> ##[0:4] !gpib_ren_n)
		else $error("remote enable not set after clear");
	a_dcl_first: assert property ($rose(gpib_dav_n_oe) && nb_q == 2'h0 |->
		!gpib_atn_n && gpib_dio_n_o == ~gpibc_pkg::BC_DEV_CLEAR) else $error("first byte wrong");
	a_settle_gap: assert property ($fell(gpib_dav_n_oe) && nb_q == 2'h1 |->
		!gpib_dav_n_oe [*8]) else $error("byte sent during settling");
	a_parallel_status_query_pair: assert property (gpib_eoi_n_oe |-> !gpib_atn_n && !gpib_dio_n_oe)
		else $error("parallel poll without attention");
	a_dio_stable: assert property (gpib_dav_n_oe |-> gpib_dio_n_oe && $stable(gpib_dio_n_o))
		else $error("data moved while valid");
	a_irq_masked: assert property (irq_wr && (pwdata[1] || pwdata[2]) |=> !srq_irq [*2])
		else $error("irq delivered while not enabled");
	c_init: cover property ($rose(gpib_ifc_n));
	c_parallel_status_query: cover property ($rose(gpib_eoi_n_oe));
	c_irq: cover property ($rose(srq_irq));
endmodule
bind gpibc_top gpibc_props #(.IFC_CYCLES(IFC_CYCLES)) u_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .gpib_ifc_n, .gpib_ren_n,
	.gpib_atn_n, .gpib_dav_n_oe, .gpib_eoi_n_oe, .gpib_dio_n_oe, .srq_irq, .gpib_dio_n_o
);

// [verif/gpibc_instr.sv]
// behavioural instrument: listens, talks on any talk address, answers polls
// assumes bus levels resolved by the bench, pull-ups on all lines
`timescale 1ns/1ps
module gpibc_instr #(
	parameter logic [4:0] ADDR = 5'h03
) (
	input wire logic pclk, raise, atn_n, eoi_n, dav_n, nrfd_n, ndac_n, acc_oe,
	input wire logic [7:0] dio_n,
	output logic dav_o, ndac_o, srq_n,
	output logic [7:0] dio_o, last_cmd, last_dat
);
	logic req = 1'b0, spe = 1'b0, talk = 1'b0, dav_q = 1'b1, pp;
	logic [4:0] ta = 5'h00;
	logic [7:0] sb, b, dio_q = 8'hFF;
	initial dav_o = 1'b1;
	assign b = ~dio_n;
	assign srq_n = !req;
	assign ndac_o = !dav_n;
	assign pp = !atn_n && !eoi_n && req;
	assign dio_o = dio_q & (pp ? 8'hFB : 8'hFF);
	assign sb = spe ? {1'b0, req && ta == ADDR, 6'h00} : 8'hA5;
	always @(posedge pclk) begin
		dav_q <= dav_n;
		if (raise)
			req <= 1'b1;
		if (dav_q && !dav_n && dav_o) begin
			if (!atn_n) begin
				last_cmd <= b;
				case (b)
					8'h14: {spe, talk} <= 2'b00;
					8'h18: spe <= 1'b1;
					8'h19: spe <= 1'b0;
					8'h5F: talk <= 1'b0;
					default: if (b[7:5] == 3'b010) {talk, ta} <= {1'b1, b[4:0]};
				endcase
			end else
				last_dat <= b;
		end
		if (dav_o && talk && atn_n && acc_oe && nrfd_n) begin
			dio_q <= ~sb;
			dav_o <= 1'b0;
		end else if (!dav_o && (ndac_n || !atn_n)) begin
			dio_q <= 8'hFF;
			dav_o <= 1'b1;
			if (sb[6])
				req <= 1'b0;
		end
	end
endmodule

// [verif/test_gpib_controller_service_request.sv]
// self-checking bench: apb master tasks, one instrument on resolved wires
// assumes package, design, checker and instrument compiled before it
`timescale 1ns/1ps
module test_gpib_controller_service_request;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic raise = 1'b0, pready, pslverr, er, srq_irq, m_dav, m_ndac, gpib_srq_n;
	logic [7:0] paddr = 8'h00, gpib_dio_n_o, m_dio, last_cmd, last_dat;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic gpib_ifc_n, gpib_ren_n, gpib_atn_n, gpib_eoi_n_o, gpib_eoi_n_oe, gpib_dav_n_o;
	logic gpib_dav_n_oe, gpib_nrfd_n_o, gpib_nrfd_n_oe, gpib_ndac_n_o, gpib_ndac_n_oe;
	logic gpib_dio_n_oe;
	wire gpib_eoi_n_i = gpib_eoi_n_oe ? gpib_eoi_n_o : 1'b1;
	wire gpib_dav_n_i = (gpib_dav_n_oe ? gpib_dav_n_o : 1'b1) & m_dav;
	wire gpib_nrfd_n_i = gpib_nrfd_n_oe ? gpib_nrfd_n_o : 1'b1;
	wire gpib_ndac_n_i = (gpib_ndac_n_oe ? gpib_ndac_n_o : 1'b1) & m_ndac;
	wire [7:0] gpib_dio_n_i = (gpib_dio_n_oe ? gpib_dio_n_o : 8'hFF) & m_dio;
	int n_mismatch = 0;
	int total_checks = 0;
	always #4 pclk = ~pclk;
	gpibc_top #(.IFC_CYCLES(20)) dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .gpib_ifc_n, .gpib_ren_n, .gpib_atn_n, .gpib_srq_n, .gpib_eoi_n_i,
		.gpib_eoi_n_o, .gpib_eoi_n_oe, .gpib_dav_n_i, .gpib_dav_n_o, .gpib_dav_n_oe,
		.gpib_nrfd_n_i, .gpib_nrfd_n_o, .gpib_nrfd_n_oe, .gpib_ndac_n_i, .gpib_ndac_n_o,
		.gpib_ndac_n_oe, .gpib_dio_n_i, .gpib_dio_n_o, .gpib_dio_n_oe, .srq_irq
	);
	gpibc_instr u_inst (
		.pclk, .raise, .atn_n(gpib_atn_n), .eoi_n(gpib_eoi_n_i), .dav_n(gpib_dav_n_i),
		.nrfd_n(gpib_nrfd_n_i), .ndac_n(gpib_ndac_n_i), .acc_oe(gpib_ndac_n_oe),
		.dio_n(gpib_dio_n_i), .dav_o(m_dav), .ndac_o(m_ndac), .srq_n(gpib_srq_n),
		.dio_o(m_dio), .last_cmd, .last_dat
	);
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmd(input logic [3:0] op, input logic [4:0] a, input logic [7:0] b = 8'h00);
		xfer(1'b1, gpibc_pkg::REG_CMD, {8'h0, b, 3'h0, a, 4'h0, op});
		for (int i = 0; i < 3000; i++) begin
			xfer(1'b0, gpibc_pkg::REG_STATUS, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		chk("idle", 32'h0, 32'(rd[0]));
	endtask
	task automatic irq(input logic [3:0] c);
		xfer(1'b1, gpibc_pkg::REG_IRQCTL, {28'h0, c});
	endtask
	task automatic srq();
		@(posedge pclk);
		raise <= 1'b1;
		@(posedge pclk);
		raise <= 1'b0;
		repeat (4) @(negedge pclk);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge pclk);
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, gpibc_pkg::REG_SETTLE, 32'h0);
		chk("settle", 32'h0001E848, rd);
		xfer(1'b1, gpibc_pkg::REG_SETTLE, 32'hA);
		cmd(gpibc_pkg::OP_INIT, 5'h0);
		chk("ren", 32'h0, 32'(gpib_ren_n));
		chk("dcl", 32'h14, 32'(last_cmd));
		$display("init done");
		for (int i = 0; i < 16; i++) xfer(1'b1, gpibc_pkg::REG_TXDATA, 32'(i + 8'h30));
		xfer(1'b0, gpibc_pkg::REG_STATUS, 32'h0);
		chk("full", 32'h1, 32'(rd[7]));
		cmd(gpibc_pkg::OP_SEND, 5'h3);
		chk("sent", 32'h3F, 32'({rd[7], last_dat}));
		cmd(gpibc_pkg::OP_RECV, 5'h3);
		xfer(1'b0, gpibc_pkg::REG_RXDATA, 32'h0);
		chk("recv", 32'hA5, 32'(rd[7:0]));
		$display("data done");
		irq(4'h1);
		srq();
		chk("irq on", 32'h1, 32'(srq_irq));
		cmd(gpibc_pkg::OP_PARALLEL_STATUS_QUERY, 5'h0);
		xfer(1'b0, gpibc_pkg::REG_PARALLEL_STATUS_QUERY, 32'h0);
		chk("parallel_status_query", 32'h4, 32'(rd[7:0]));
		cmd(gpibc_pkg::OP_SERVICE, 5'h0);
		chk("found", 32'h7, 32'({rd[12:8], rd[2]}));
		xfer(1'b0, gpibc_pkg::REG_SPOLL, 32'h0);
		chk("spoll", 32'h40, 32'(rd[7:0]));
		xfer(1'b0, gpibc_pkg::REG_RXDATA, 32'h0);
		chk("svc data", 32'hA5, 32'(rd[7:0]));
		irq(4'h8);
		chk("irq clr", 32'h0, 32'(srq_irq));
		irq(4'h2);
		srq();
		xfer(1'b0, gpibc_pkg::REG_STATUS, 32'h0);
		chk("dropped", 32'h0, 32'({srq_irq, rd[4]}));
		cmd(gpibc_pkg::OP_SERVICE, 5'h0);
		irq(4'h4);
		srq();
		xfer(1'b0, gpibc_pkg::REG_STATUS, 32'h0);
		chk("held", 32'h1, 32'({srq_irq, rd[4]}));
		irq(4'h1);
		chk("delivered", 32'h1, 32'(srq_irq));
		$display("irq done");
		cmd(gpibc_pkg::OP_POLL, 5'h3);
		chk("poll", 32'h7, 32'({rd[12:8], rd[2]}));
		cmd(gpibc_pkg::OP_RAWCMD, 5'h0, 8'h43);
		chk("raw cmd", 32'h43, 32'(last_cmd));
		cmd(gpibc_pkg::OP_RAWRD, 5'h0);
		xfer(1'b0, gpibc_pkg::REG_RXDATA, 32'h0);
		chk("raw rd", 32'hA5, 32'(rd[7:0]));
		xfer(1'b1, gpibc_pkg::REG_CTRL, 32'h3);
		srq();
		// busy with auto service: this command is ignored
		cmd(4'h0, 5'h0);
		chk("auto", 32'h7, 32'({rd[12:8], rd[2]}));
		$display("poll done");
		xfer(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, 32'(er));
		$display("map done");
		end_sim();
	end
endmodule
